// >>> pkg/scha_pkg.sv
// constants shared by the host access and reset logic
package scha_pkg;

  // ----------------------------------------------------------------
  // timing, in peripheral clock cycles
  // ----------------------------------------------------------------
  localparam int RECOV_CYC   = 4;  // access recovery after a strobe
  localparam int STRETCH_CYC = 5;  // reset stretch, upper bound of 4..5
  localparam int CNT_W       = 4;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CMD  = 4'h0;
  localparam logic [3:0] ADDR_WR2  = 4'h2;
  localparam logic [3:0] ADDR_WR3  = 4'h3;
  localparam logic [3:0] ADDR_WR4  = 4'h4;
  localparam logic [3:0] ADDR_WR5  = 4'h5;
  localparam logic [3:0] ADDR_SEV  = 4'h7;
  localparam logic [3:0] ADDR_DATA = 4'h8;
  localparam logic [3:0] ADDR_MIC  = 4'h9;
  localparam logic [3:0] ADDR_MISC = 4'ha;
  localparam logic [3:0] ADDR_RD11 = 4'hb;
  localparam logic [3:0] ADDR_CFG  = 4'hf;

  // ----------------------------------------------------------------
  // field positions and codes
  // ----------------------------------------------------------------
  localparam int         PTR_W          = 3;
  localparam int         CODE_LSB       = 3;
  localparam logic [2:0] CODE_POINT_HIGH = 3'h1;
  localparam int         RST_LSB        = 6;
  localparam logic [1:0] RST_NONE       = 2'h0;
  localparam logic [1:0] RST_CH_B       = 2'h1;
  localparam logic [1:0] RST_CH_A       = 2'h2;
  localparam logic [1:0] RST_HW         = 2'h3;
  localparam int         CFG_ALT_BIT    = 0;
  localparam int         CFG_FIFO_BIT   = 2;
  localparam int         ALT_EXT_BIT    = 6;
  localparam logic       CH_A           = 1'b1;

  // ----------------------------------------------------------------
  // reset values: kept bits and forced bits, index is the address
  // ----------------------------------------------------------------
  localparam logic [15:0][7:0] HW_KEEP = {
    8'h00, 8'hc0, 8'hff, 8'hff, 8'h00, 8'h00, 8'h03, 8'hff,
    8'hff, 8'hff, 8'h61, 8'hfb, 8'hfe, 8'hff, 8'h24, 8'h00};
  localparam logic [15:0][7:0] HW_SET = {
    8'hf8, 8'h30, 8'h00, 8'h00, 8'h08, 8'h00, 8'hc0, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [15:0][7:0] CH_KEEP = {
    8'h00, 8'hc3, 8'hff, 8'hff, 8'hff, 8'h60, 8'hdf, 8'hff,
    8'hff, 8'hff, 8'h61, 8'hfb, 8'hfe, 8'hff, 8'h24, 8'h00};
  localparam logic [15:0][7:0] CH_SET = {
    8'hf8, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] ALT7_RST = 8'h20;
  localparam logic [7:0] ST0_KEEP = 8'hb8;
  localparam logic [7:0] ST0_SET  = 8'h44;
  localparam logic [7:0] ST1_KEEP = 8'h01;
  localparam logic [7:0] ST1_SET  = 8'h06;
  localparam logic [7:0] ST10_KEEP = 8'h40;
  localparam logic [5:0] IP_CH_A  = 6'h38;
  localparam logic [5:0] IP_CH_B  = 6'h07;

  // synchroniser idle value {as,ds,iack,ab,dc,ce,wr,rd,din}
  localparam logic [15:0] PIN_IDLE = 16'he700;

endpackage : scha_pkg

// >>> pkg/scha_pin_if.sv
// synchronised host pins passed from the synchroniser to the port logic
`timescale 1ns/1ps
interface scha_pin_if;
  logic       rd_n;
  logic       wr_n;
  logic       ce_n;
  logic       dc;
  logic       ab;
  logic       iack_n;
  logic       as_n;
  logic       ds_n;
  logic [7:0] din;
  modport src (output rd_n, wr_n, ce_n, dc, ab, iack_n, as_n, ds_n, din);
  modport dst (input rd_n, wr_n, ce_n, dc, ab, iack_n, as_n, ds_n, din);
endinterface : scha_pin_if

// >>> hw/scha_pin_sync.sv
// three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/1ps
module scha_pin_sync
  import scha_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       ce_n,
  input  wire logic       dc,
  input  wire logic       ab,
  input  wire logic       int_ack_n,
  input  wire logic       addr_strobe_n,
  input  wire logic       data_strobe_n,
  input  wire logic [7:0] din,
  scha_pin_if.src         pins
);
  logic [15:0] raw;
  logic [15:0] s1_q;
  logic [15:0] s2_q;
  logic [15:0] s3_q;
  logic [15:0] q_q;

  assign raw = {addr_strobe_n, data_strobe_n, int_ack_n, ab, dc, ce_n,
                wr_n, rd_n, din};

  // stage one feeds stage two only; filtered value moves on agreement
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_q <= PIN_IDLE;
      s2_q <= PIN_IDLE;
      s3_q <= PIN_IDLE;
      q_q  <= PIN_IDLE;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q  <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & q_q);
    end
  end

  assign {pins.as_n, pins.ds_n, pins.iack_n, pins.ab, pins.dc,
          pins.ce_n, pins.wr_n, pins.rd_n, pins.din} = q_q;

endmodule : scha_pin_sync

// >>> hw/scha_guard.sv
// recovery and reset-stretch counter gating new accesses
`timescale 1ns/1ps
module scha_guard
  import scha_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             hold,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_cnt,
  output logic                  busy
);
  logic [CNT_W-1:0] cnt_q;

  // held at the stretch count while reset is held, then runs down
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (hold) begin
      cnt_q <= CNT_W'(STRETCH_CYC);
    end else if (load) begin
      cnt_q <= load_cnt;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign busy = hold | (cnt_q != '0);

endmodule : scha_guard

// >>> hw/scha_top.sv
// host access port: pointer, enhancement enables and resets
`timescale 1ns/1ps

module scha_top
  import scha_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        ce_n,
  input  wire logic        dc,
  input  wire logic        ab,
  input  wire logic        int_ack_n,
  input  wire logic        addr_strobe_n,
  input  wire logic        data_strobe_n,
  input  wire logic [7:0]  data_in,
  input  wire logic [7:0]  rx_data,
  input  wire logic [15:0] fifo_status,
  input  wire logic [5:0]  int_src,
  output logic      [7:0]  data_out,
  output logic             data_oe,
  output logic      [7:0]  tx_data,
  output logic             tx_wr,
  output logic             rx_rd,
  output logic             xfer_ch,
  output logic      [5:0]  int_pending_bits,
  output logic      [1:0]  status_fifo_en,
  output logic      [1:0]  alt_seven_en,
  output logic      [1:0]  ext_read_en,
  output logic             int_reset,
  output logic             acc_busy
);

  // ----------------------------------------------------------------
  // synchronised pins and guard counter
  // ----------------------------------------------------------------
  scha_pin_if pins ();

  scha_pin_sync u_sync (
    .clock         (clock),
    .rst_n         (rst_n),
    .rd_n          (rd_n),
    .wr_n          (wr_n),
    .ce_n          (ce_n),
    .dc            (dc),
    .ab            (ab),
    .int_ack_n     (int_ack_n),
    .addr_strobe_n (addr_strobe_n),
    .data_strobe_n (data_strobe_n),
    .din           (data_in),
    .pins          (pins.src)
  );

  logic             hw_hold;
  logic             busy;
  logic             guard_load;
  logic [CNT_W-1:0] guard_cnt;

  scha_guard u_guard (
    .clock    (clock),
    .rst_n    (rst_n),
    .hold     (hw_hold),
    .load     (guard_load),
    .load_cnt (guard_cnt),
    .busy     (busy)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] wreg_q [2][16];  // write registers per channel
  logic [7:0] alt7_q [2];
  logic [7:0] st0_q  [2];
  logic [7:0] st1_q  [2];
  logic [7:0] st10_q [2];
  logic [3:0] ptr_q;
  logic [5:0] ip_q;
  logic       acc_q;
  logic       iack_hi_q;
  logic [7:0] data_out_q;
  logic       data_oe_q;
  logic [7:0] tx_data_q;
  logic       tx_wr_q;
  logic       rx_rd_q;
  logic       xfer_ch_q;
  logic [1:0] fifo_en_q;
  logic [1:0] alt_en_q;
  logic [1:0] ext_en_q;
  logic       int_reset_q;
  logic       acc_busy_q;

  logic       acc;
  logic       start;
  logic       is_rd;
  logic       ch;
  logic       wr_ctl;
  logic       sw_cmd;
  logic [1:0] rst_code;
  logic       sw_hw;
  logic       sw_ch;
  logic       sw_ch_sel;
  logic [3:0] eff_addr;
  logic [7:0] rdata;

  // resets a byte: undefined bits are kept, defined bits forced
  function automatic logic [7:0] rst_byte(input logic       hw,
                                          input logic [3:0] a,
                                          input logic [7:0] old);
    if (hw)
      return (old & HW_KEEP[a]) | HW_SET[a];
    return (old & CH_KEEP[a]) | CH_SET[a];
  endfunction : rst_byte

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  assign hw_hold  = !pins.as_n && !pins.ds_n;
  assign acc      = !pins.ce_n && (!pins.rd_n || !pins.wr_n);
  assign is_rd    = !pins.rd_n;
  assign ch       = pins.ab;
  // a new access needs a prior high acknowledge and an idle guard
  assign start    = acc && !acc_q && iack_hi_q && !busy;
  assign eff_addr = pins.dc ? ADDR_DATA : ptr_q;
  assign wr_ctl   = start && !is_rd && !pins.dc;
  assign sw_cmd   = wr_ctl && (ptr_q == ADDR_MIC);
  assign rst_code = pins.din[RST_LSB +: 2];
  assign sw_hw    = sw_cmd && (rst_code == RST_HW);
  assign sw_ch    = sw_cmd && (rst_code == RST_CH_A ||
                               rst_code == RST_CH_B);
  assign sw_ch_sel = (rst_code == RST_CH_A);

  // recovery on every access, longer when a reset is commanded
  assign guard_load = start;
  assign guard_cnt  = (sw_hw || sw_ch) ?
                      CNT_W'(RECOV_CYC + STRETCH_CYC) :
                      CNT_W'(RECOV_CYC);

  // edge detect and acknowledge sample, both on synchronised pins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      acc_q     <= 1'b0;
      iack_hi_q <= 1'b0;
    end else begin
      acc_q     <= acc;
      iack_hi_q <= pins.iack_n;
    end
  end

  // ----------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    logic fifo;
    logic ext;
    fifo  = wreg_q[ch][ADDR_CFG][CFG_FIFO_BIT];
    ext   = wreg_q[ch][ADDR_CFG][CFG_ALT_BIT] &&
            alt7_q[ch][ALT_EXT_BIT];
    rdata = 8'h00;
    case (eff_addr)
      4'h0: rdata = st0_q[ch];
      4'h1: rdata = st1_q[ch];
      4'h2: rdata = wreg_q[ch][ADDR_WR2];
      4'h3: rdata = (ch == CH_A) ? {2'h0, ip_q} : 8'h00;
      4'h4: rdata = ext ? wreg_q[ch][ADDR_WR4] : st0_q[ch];
      4'h5: rdata = ext ? wreg_q[ch][ADDR_WR5] : st1_q[ch];
      4'h6: rdata = fifo ? fifo_status[7:0] :
                    wreg_q[ch][ADDR_WR2];
      4'h7: rdata = fifo ? fifo_status[15:8] :
                    ((ch == CH_A) ? {2'h0, ip_q} : 8'h00);
      4'h8: rdata = rx_data;
      4'h9: rdata = ext ? wreg_q[ch][ADDR_WR3] :
                    wreg_q[ch][4'hd];
      4'ha: rdata = st10_q[ch];
      4'hb: rdata = ext ? wreg_q[ch][ADDR_MISC] :
                    wreg_q[ch][ADDR_CFG];
      4'he: rdata = ext ? alt7_q[ch] : wreg_q[ch][4'he];
      default: rdata = wreg_q[ch][eff_addr];
    endcase
  end

  // ----------------------------------------------------------------
  // shared register pointer
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ptr_q <= 4'h0;
    end else if (hw_hold || sw_hw) begin
      ptr_q <= 4'h0;
    end else if (start && !pins.dc) begin
      if (!is_rd && ptr_q == ADDR_CMD)
        ptr_q <= {pins.din[CODE_LSB +: 3] == CODE_POINT_HIGH,
                  pins.din[PTR_W-1:0]};
      else
        ptr_q <= 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // write registers, software and hardware resets
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int c = 0; c < 2; c++) begin
        for (int a = 0; a < 16; a++)
          wreg_q[c][a] <= HW_SET[a];
        alt7_q[c] <= ALT7_RST;
      end
    end else if (hw_hold || sw_hw) begin
      for (int c = 0; c < 2; c++) begin
        for (int a = 0; a < 16; a++)
          wreg_q[c][a] <= rst_byte(1'b1, 4'(a), wreg_q[c][a]);
        alt7_q[c] <= ALT7_RST;
      end
    end else if (sw_ch) begin
      for (int a = 0; a < 16; a++)
        if (4'(a) != ADDR_MIC)
          wreg_q[sw_ch_sel][a] <=
            rst_byte(1'b0, 4'(a), wreg_q[sw_ch_sel][a]);
      alt7_q[sw_ch_sel] <= ALT7_RST;
      for (int c = 0; c < 2; c++)
        wreg_q[c][ADDR_MIC] <= rst_byte(1'b0, ADDR_MIC, pins.din);
    end else if (wr_ctl) begin
      if (ptr_q == ADDR_MIC || ptr_q == ADDR_WR2) begin
        for (int c = 0; c < 2; c++)
          wreg_q[c][ptr_q] <= pins.din;
      end else if (ptr_q == ADDR_SEV &&
                   wreg_q[ch][ADDR_CFG][CFG_ALT_BIT]) begin
        alt7_q[ch] <= pins.din;
      end else begin
        wreg_q[ch][ptr_q] <= pins.din;
      end
    end
  end

  // ----------------------------------------------------------------
  // status registers, reset values only at this level
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int c = 0; c < 2; c++) begin
        st0_q[c]  <= ST0_SET;
        st1_q[c]  <= ST1_SET;
        st10_q[c] <= 8'h00;
      end
    end else if (hw_hold || sw_hw) begin
      for (int c = 0; c < 2; c++) begin
        st0_q[c]  <= (st0_q[c] & ST0_KEEP) | ST0_SET;
        st1_q[c]  <= (st1_q[c] & ST1_KEEP) | ST1_SET;
        st10_q[c] <= st10_q[c] & ST10_KEEP;
      end
    end else if (sw_ch) begin
      st0_q[sw_ch_sel]  <= (st0_q[sw_ch_sel] & ST0_KEEP) | ST0_SET;
      st1_q[sw_ch_sel]  <= (st1_q[sw_ch_sel] & ST1_KEEP) | ST1_SET;
      st10_q[sw_ch_sel] <= st10_q[sw_ch_sel] & ST10_KEEP;
    end
  end

  // ----------------------------------------------------------------
  // interrupt pending bits, frozen while pointing at two or three
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ip_q <= 6'h00;
    end else if (hw_hold || sw_hw) begin
      ip_q <= 6'h00;
    end else if (sw_ch) begin
      ip_q <= ip_q & ~(sw_ch_sel ? IP_CH_A : IP_CH_B);
    end else if (ptr_q != ADDR_WR2 && ptr_q != ADDR_WR3) begin
      ip_q <= int_src;
    end
  end

  // ----------------------------------------------------------------
  // bus and datapath outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      data_out_q <= 8'h00;
      data_oe_q  <= 1'b0;
      tx_data_q  <= 8'h00;
      tx_wr_q    <= 1'b0;
      rx_rd_q    <= 1'b0;
      xfer_ch_q  <= 1'b0;
    end else begin
      data_oe_q <= !pins.ce_n && !pins.rd_n;
      tx_wr_q   <= start && !is_rd && (eff_addr == ADDR_DATA);
      rx_rd_q   <= start && is_rd && (eff_addr == ADDR_DATA);
      if (start) begin
        xfer_ch_q <= ch;
        if (is_rd)
          data_out_q <= rdata;
        else
          tx_data_q <= pins.din;
      end
    end
  end

  // ----------------------------------------------------------------
  // enhancement enables and reset indication
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fifo_en_q   <= 2'b00;
      alt_en_q    <= 2'b00;
      ext_en_q    <= 2'b00;
      int_reset_q <= 1'b1;
      acc_busy_q  <= 1'b0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        fifo_en_q[c] <= wreg_q[c][ADDR_CFG][CFG_FIFO_BIT];
        alt_en_q[c]  <= wreg_q[c][ADDR_CFG][CFG_ALT_BIT];
        ext_en_q[c]  <= wreg_q[c][ADDR_CFG][CFG_ALT_BIT] &&
                        alt7_q[c][ALT_EXT_BIT];
      end
      int_reset_q <= hw_hold || sw_hw;
      acc_busy_q  <= busy;
    end
  end

  assign data_out         = data_out_q;
  assign data_oe          = data_oe_q;
  assign tx_data          = tx_data_q;
  assign tx_wr            = tx_wr_q;
  assign rx_rd            = rx_rd_q;
  assign xfer_ch          = xfer_ch_q;
  assign int_pending_bits = ip_q;
  assign status_fifo_en   = fifo_en_q;
  assign alt_seven_en     = alt_en_q;
  assign ext_read_en      = ext_en_q;
  assign int_reset        = int_reset_q;
  assign acc_busy         = acc_busy_q;

endmodule : scha_top

// >>> verification/scha_asserts.sv
// checker of the host access port outputs
`timescale 1ns/1ps
module scha_asserts
  import scha_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rd_n,
  input wire logic ce_n,
  input wire logic int_ack_n,
  input wire logic addr_strobe_n,
  input wire logic data_strobe_n,
  input wire logic data_oe,
  input wire logic tx_wr,
  input wire logic rx_rd,
  input wire logic int_reset,
  input wire logic acc_busy
);
  // ------------------------------------------------------------
  // port relations, all in the peripheral clock domain
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // bus floats once select or read has been gone past the sync lag
  property p_oe_off; (ce_n || rd_n) [*6] |-> !data_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus driven idle");
  property p_oe_on; (!ce_n && !rd_n) [*7] |-> data_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("bus not driven");
  property p_hold; (!addr_strobe_n && !data_strobe_n) [*6] |-> int_reset;
  endproperty
  a_hold: assert property (p_hold) else $error("strobe reset lost");
  sequence s_rel;
    (!addr_strobe_n && !data_strobe_n) [*5] ##1
      (addr_strobe_n || data_strobe_n);
  endsequence
  // busy through the sync lag and the stretch, idle right after it
  property p_stretch;
    s_rel |-> acc_busy [*8] ##2 acc_busy ##1 !acc_busy;
  endproperty
  a_stretch: assert property (p_stretch) else $error("no stretch");
  property p_tx_one; tx_wr |=> !tx_wr; endproperty
  a_tx_one: assert property (p_tx_one) else $error("long write");
  property p_rx_one; rx_rd |=> !rx_rd; endproperty
  a_rx_one: assert property (p_rx_one) else $error("long read");
  property p_busy; (tx_wr || rx_rd) |=> acc_busy; endproperty
  a_busy: assert property (p_busy) else $error("no recovery");
  property p_ack; (!int_ack_n) [*8] |-> !tx_wr && !rx_rd; endproperty
  a_ack: assert property (p_ack) else $error("access in ack");
  property p_idle; ce_n [*8] |-> !tx_wr && !rx_rd; endproperty
  a_idle: assert property (p_idle) else $error("unselected access");
  c_wr: cover property (tx_wr);
  c_rd: cover property (rx_rd);
  c_hw: cover property (int_reset && !addr_strobe_n);
endmodule : scha_asserts

// >>> verification/scha_host.sv
// host processor model driving the strobe and select pins
`timescale 1ns/1ps
module scha_host (
  input  wire logic       clock,
  input  wire logic [7:0] data_out,
  output logic            rd_n,
  output logic            wr_n,
  output logic            ce_n,
  output logic            dc,
  output logic            ab,
  output logic            int_ack_n,
  output logic            addr_strobe_n,
  output logic            data_strobe_n,
  output logic      [7:0] data_in
);
  // ------------------------------------------------------------
  // idle pins and bus cycles
  // ------------------------------------------------------------
  initial begin
    {rd_n, wr_n, ce_n, int_ack_n} = 4'hf;
    {addr_strobe_n, data_strobe_n, dc, ab} = 4'hc;
    data_in = 8'ha5;
  end
  // one read or write; dc and ab settle a cycle before the select and the strobe
  task automatic acc(input logic w, input logic d_c, input logic a_b,
                     input logic [7:0] d, output logic [7:0] rd_q);
    @(posedge clock);
    #1;
    dc = d_c;
    ab = a_b;
    data_in = w ? d : ~data_in;
    @(posedge clock);
    #1;
    ce_n = 1'b0;
    wr_n = !w;
    rd_n = w;
    repeat (8) @(posedge clock);
    #1;
    rd_q = data_out;
    {rd_n, wr_n, ce_n} = 3'h7;
    data_in = ~data_in;
    repeat (8) @(posedge clock);
  endtask : acc
  // acknowledge level, sampled by the device before any access
  task automatic setack(input logic v);
    #1;
    int_ack_n = v;
  endtask : setack
  // both strobes low together request a hardware reset
  task automatic strobes(input logic v);
    #1;
    addr_strobe_n = v;
    data_strobe_n = v;
  endtask : strobes
endmodule : scha_host

// >>> verification/serial_ctrl_host_access_reset_bench.sv
// testbench of the host access port against a host model
`timescale 1ns/1ps
module serial_ctrl_host_access_reset_bench;
  import scha_pkg::*;
  // ------------------------------------------------------------
  // signals, instances and counters
  // ------------------------------------------------------------
  logic        clock, rst_n, rd_n, wr_n, ce_n, dc, ab, int_ack_n;
  logic        addr_strobe_n, data_strobe_n, data_oe, tx_wr, rx_rd;
  logic        xfer_ch, int_reset, acc_busy;
  logic [7:0]  rx_data, data_in, data_out, tx_data, q;
  logic [15:0] fifo_status;
  logic [5:0]  int_src, int_pending_bits;
  logic [1:0]  status_fifo_en, alt_seven_en, ext_read_en;
  int          failures, checked, cycles, nwr, nbusy, n;
  scha_top scha_top_i (.clock, .rst_n, .rd_n, .wr_n, .ce_n, .dc, .ab,
    .int_ack_n, .addr_strobe_n, .data_strobe_n, .data_in, .rx_data,
    .fifo_status, .int_src, .data_out, .data_oe, .tx_data, .tx_wr, .rx_rd,
    .xfer_ch, .int_pending_bits, .status_fifo_en, .alt_seven_en,
    .ext_read_en, .int_reset, .acc_busy);
  scha_host scha_host_i (.clock, .data_out, .rd_n, .wr_n, .ce_n, .dc, .ab,
    .int_ack_n, .addr_strobe_n, .data_strobe_n, .data_in);
  // free-running clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // cycle, write pulse and busy counters with a hang limit
  always @(posedge clock) begin
    cycles++;
    if (tx_wr === 1'b1) nwr++;
    if (acc_busy === 1'b1) nbusy++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // pointer load, then a control write or read through it
  task automatic ptr(input logic [3:0] r, input logic ch);
    scha_host_i.acc(1'b1, 1'b0, ch,
      {2'h0, (r[3] ? CODE_POINT_HIGH : 3'h0), r[2:0]}, q);
  endtask : ptr
  task automatic wreg(input logic [3:0] r, input logic ch, input logic [7:0] v);
    ptr(r, ch);
    scha_host_i.acc(1'b1, 1'b0, ch, v, q);
  endtask : wreg
  task automatic rreg(input logic [3:0] r, input logic ch);
    ptr(r, ch);
    scha_host_i.acc(1'b0, 1'b0, ch, 8'h00, q);
  endtask : rreg
  // enhancement enables and extended readback on channel a
  task automatic t_enh;
    wreg(4'hf, 1'b1, 8'h05);
    chk("fifo en", {6'h00, status_fifo_en}, 8'h02);
    chk("alt en", {6'h00, alt_seven_en}, 8'h02);
    chk("ext en", {6'h00, ext_read_en}, 8'h00);
    wreg(4'h7, 1'b1, 8'h40);
    chk("ext en", {6'h00, ext_read_en}, 8'h02);
    wreg(4'h4, 1'b1, 8'h5a);
    rreg(4'h4, 1'b1);
    chk("read four", q, 8'h5a);
    rreg(4'he, 1'b1);
    chk("read alt", q, 8'h40);
    wreg(4'hf, 1'b1, 8'h04);
    chk("alt en", {6'h00, alt_seven_en}, 8'h00);
    chk("ext en", {6'h00, ext_read_en}, 8'h00);
    chk("fifo en", {6'h00, status_fifo_en}, 8'h02);
    rreg(4'h6, 1'b1);
    chk("fifo low", q, 8'h36);
    rreg(4'h7, 1'b1);
    chk("fifo high", q, 8'h9c);
  endtask : t_enh
  // data accesses leave the pointer, a control read clears it
  task automatic t_ptr;
    wreg(4'hf, 1'b1, 8'h05);
    ptr(4'h4, 1'b1);
    n = nwr;
    scha_host_i.acc(1'b1, 1'b1, 1'b1, 8'h3c, q);
    chk("tx count", 8'(nwr - n), 8'h01);
    chk("tx data", tx_data, 8'h3c);
    scha_host_i.acc(1'b0, 1'b1, 1'b1, 8'h00, q);
    chk("rx data", q, 8'hc3);
    scha_host_i.acc(1'b0, 1'b0, 1'b1, 8'h00, q);
    chk("pointer kept", q, 8'h5a);
    scha_host_i.acc(1'b0, 1'b0, 1'b1, 8'h00, q);
    chk("pointer zero", q & 8'h47, 8'h44);
  endtask : t_ptr
  // strobe reset, access in the stretch, reset values
  task automatic t_hw;
    n = nwr;
    scha_host_i.strobes(1'b0);
    repeat (8) @(posedge clock);
    chk("hw hold", {7'h00, int_reset}, 8'h01);
    scha_host_i.strobes(1'b1);
    scha_host_i.acc(1'b1, 1'b1, 1'b0, 8'h11, q);
    chk("tx count", 8'(nwr - n), 8'h00);
    chk("channel", {7'h00, xfer_ch}, 8'h01);
    chk("enables", {2'h0, status_fifo_en, alt_seven_en, ext_read_en},
        8'h00);
    wreg(4'hf, 1'b0, 8'h01);
    chk("ext en", {6'h00, ext_read_en}, 8'h00);
    wreg(4'h7, 1'b0, 8'h40);
    rreg(4'h4, 1'b0);
    chk("misc four", q & 8'h04, 8'h04);
    chk("channel", {7'h00, xfer_ch}, 8'h00);
    rreg(4'h9, 1'b0);
    chk("rx param", q & 8'h01, 8'h00);
  endtask : t_hw
  // each reset command code, its reach and its busy span
  task automatic t_sw;
    for (int i = 1; i < 4; i++) begin
      wreg(4'hf, 1'b0, 8'h05);
      wreg(4'hf, 1'b1, 8'h05);
      ptr(4'h9, 1'b0);
      n = nbusy;
      scha_host_i.acc(1'b1, 1'b0, 1'b0, {i[1:0], 6'h00}, q);
      chk("busy span", 8'(nbusy - n), 8'(RECOV_CYC + STRETCH_CYC));
      chk("alt en", {6'h00, alt_seven_en}, {6'h00, ~i[1:0]});
    end
  endtask : t_sw
  // acknowledge low refuses, pending bits follow the sources
  task automatic t_ack;
    n = nwr;
    scha_host_i.setack(1'b0);
    repeat (3) @(posedge clock);
    scha_host_i.acc(1'b1, 1'b1, 1'b0, 8'h22, q);
    chk("tx count", 8'(nwr - n), 8'h00);
    scha_host_i.setack(1'b1);
    repeat (6) @(posedge clock);
    scha_host_i.acc(1'b1, 1'b1, 1'b0, 8'h22, q);
    chk("tx count", 8'(nwr - n), 8'h01);
    #1;
    int_src = 6'h2a;
    repeat (6) @(posedge clock);
    chk("pending", {2'h0, int_pending_bits}, 8'h2a);
  endtask : t_ack
  // reset, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    int_src = 6'h00;
    rx_data = 8'hc3;
    fifo_status = 16'h9c36;
    repeat (4) @(posedge clock);
    #1;
    rst_n = 1'b1;
    repeat (6) @(posedge clock);
    t_enh();
    t_ptr();
    t_hw();
    t_sw();
    t_ack();
    give_verdict();
  end
endmodule : serial_ctrl_host_access_reset_bench
bind scha_top scha_asserts scha_asserts_i (.clock, .rst_n, .rd_n, .ce_n,
  .int_ack_n, .addr_strobe_n, .data_strobe_n, .data_oe, .tx_wr, .rx_rd,
  .int_reset, .acc_busy);
